/* File: shared/kms_pkg.sv */
package kms_pkg;
   localparam int KMS_CLK_HZ = 25000000;
   localparam int KMS_SAMPLE_HZ = 48000;
   localparam int KMS_SAMPLE_CYC = KMS_CLK_HZ / KMS_SAMPLE_HZ;
   localparam int KMS_BEAT_MS = 250;
   localparam int KMS_BEAT_CYC = (KMS_CLK_HZ / 1000) * KMS_BEAT_MS;
   localparam int KMS_NOTES = 19;
   localparam int KMS_NATS = 11;
   localparam logic [4:0] KMS_REST = 5'h1F;
   localparam logic [7:0] KMS_CODE_BREAK = 8'hF0;
   localparam logic [7:0] KMS_CODE_EXT = 8'hE0;
   localparam logic [3:0] KMS_FRAME_LAST = 4'hA;
   localparam int KMS_TUNE_AW = 4;
   localparam logic [18:0] KMS_SHARP = 19'h15295;
   localparam logic [16:0] KMS_STEP [KMS_NOTES] = '{
      17'h07C27, 17'h08389, 17'h08B5A, 17'h093A4, 17'h09C6B, 17'h0A5B8,
      17'h0AF94, 17'h0BA03, 17'h0C512, 17'h0D0CB, 17'h0DD36, 17'h0EA5D,
      17'h0F84C, 17'h10711, 17'h116B4, 17'h12747, 17'h138D6, 17'h14B70,
      17'h15F26};
   localparam logic [4:0] KMS_NAT [KMS_NATS] = '{5'h01, 5'h03, 5'h05,
      5'h06, 5'h08, 5'h0A, 5'h0B, 5'h0D, 5'h0F, 5'h11, 5'h12};
   localparam logic [9:0] KMS_PIANO_X0 = 10'h080;
   localparam logic [9:0] KMS_PIANO_X1 = 10'h1E0;
   localparam logic [9:0] KMS_PIANO_Y0 = 10'h0A0;
   localparam logic [9:0] KMS_PIANO_Y1 = 10'h140;
   localparam logic [9:0] KMS_SHARP_Y = 10'h0F0;
   localparam logic [4:0] KMS_SHARP_LO = 5'h08;
   localparam logic [4:0] KMS_SHARP_HI = 5'h18;
   localparam logic [11:0] KMS_RGB_BACK = 12'h00A;
   localparam logic [11:0] KMS_RGB_LIT = 12'hF00;
   localparam logic [11:0] KMS_RGB_WHITE = 12'hFFF;
   localparam logic [11:0] KMS_RGB_BLACK = 12'h000;
   typedef enum logic [3:0] {
      KMS_IDLE = 4'b0001,
      KMS_ADDR = 4'b0010,
      KMS_LOAD = 4'b0100,
      KMS_PLAY = 4'b1000
   } kms_demo_t;
endpackage

/* File: shared/kms_ps2_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface kms_ps2_if;
   logic [7:0] code;
   logic toggle;
   modport rx (output code, output toggle);
   modport core (input code, input toggle);
endinterface
`default_nettype wire

/* File: rtl/kms_tune_rom.sv */
`timescale 1ns/10ps
`default_nettype none
module kms_tune_rom #(
   parameter int AW = kms_pkg::KMS_TUNE_AW
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [AW-1:0] addr,
   output logic [7:0] data
);
   import kms_pkg::*;
   logic [7:0] next_data;

   // Each entry is beats in [7:5] and note in [4:0]; zero beats ends it.
   always_comb begin
      case (addr)
         4'h0, 4'h1, 4'h6, 4'hB, 4'hC: next_data = 8'h2A;
         4'h2, 4'h5: next_data = 8'h2B;
         4'h3, 4'h4: next_data = 8'h2D;
         4'h7, 4'hA, 4'hD: next_data = 8'h28;
         4'h8, 4'h9: next_data = 8'h26;
         4'hE: next_data = 8'h48;
         default: next_data = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         data <= 8'h00;
      end else begin
         data <= next_data;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/kms_ps2_rx.sv */
`timescale 1ns/10ps
`default_nettype none
module kms_ps2_rx (
   input wire logic ps2_clk,
   input wire logic reset,
   input wire logic ps2_dat,
   kms_ps2_if.rx link
);
   import kms_pkg::*;
   logic [3:0] cnt, next_cnt;
   logic [9:0] shift, next_shift;
   logic [7:0] code, next_code;
   logic tog, next_tog;

   // A lost bit misaligns frames until an idle-high start slot is seen;
   // no timeout is possible here because this clock stops between frames.
   always_comb begin
      next_cnt = cnt + 4'h1;
      next_shift = {ps2_dat, shift[9:1]};
      next_code = code;
      next_tog = tog;
      if (cnt == 4'h0 && ps2_dat) begin
         next_cnt = 4'h0;
      end else if (cnt == KMS_FRAME_LAST) begin
         next_cnt = 4'h0;
         next_shift = shift;
         if (ps2_dat && !shift[0] && (^shift[9:1])) begin // [R8]
            next_code = shift[8:1];
            next_tog = ~tog;
         end
      end
   end

   always_ff @(negedge ps2_clk or posedge reset) begin
      if (reset) begin
         cnt <= 4'h0;
         shift <= 10'h000;
         code <= 8'h00;
         tog <= 1'b0;
      end else begin
         cnt <= next_cnt;
         shift <= next_shift;
         code <= next_code;
         tog <= next_tog;
      end
   end

   assign link.code = code;
   assign link.toggle = tog;
endmodule
`default_nettype wire

/* File: rtl/kms_top.sv */
// Notes on behaviour
// R1 - Built from tune store, key handler, piano drawer and tone core.
// R2 - Source switch low plays the stored tune, high plays the keyboard.
// R3 - Restart button press replays the stored tune from its first entry.
// R4 - Timbre switch low gives brass, high gives string.
// R5 - Channel one and channel two switches each mute their own output.
// R6 - Reset button returns the whole synthesizer to its initial state.
// R7 - Draw a piano on the pixel output, highlighting sounding keys; with the source switch high every held key is lit, not only the lowest.
// R8 - Keyboard frames are received and taken as piano key presses.
// R9 - Letter keys map to naturals -5..7, sharps -#4..#6 and +1.
// R10 - A note sounds while its key is held and stops on release; of several held keys only the lowest sounds.
`timescale 1ns/10ps
`default_nettype none
module kms_top #(
   parameter int BEAT_CYCLES = kms_pkg::KMS_BEAT_CYC
) (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic DEMO_RESTART_N,
   input wire logic NOTE_SOURCE_SELECT,
   input wire logic TIMBRE_SELECT,
   input wire logic CHANNEL_ONE_ENABLE,
   input wire logic CHANNEL_TWO_ENABLE,
   input wire logic PS2_CLK,
   input wire logic PS2_DAT_I,
   output logic PS2_CLK_O,
   output logic PS2_CLK_OE_N,
   output logic PS2_DAT_O,
   output logic PS2_DAT_OE_N,
   input wire logic [9:0] VGA_X,
   input wire logic [9:0] VGA_Y,
   output logic [3:0] VGA_R,
   output logic [3:0] VGA_G,
   output logic [3:0] VGA_B,
   output logic [15:0] AUDIO_LEFT,
   output logic [15:0] AUDIO_RIGHT,
   output logic AUDIO_VALID,
   output logic [kms_pkg::KMS_NOTES-1:0] KEYS_HELD
);
   import kms_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [4:0] sync1, sync2;
   logic restart_n, src_sel, timbre, ch1_en, ch2_en;
   logic tog1, tog2, tog3;
   logic brk, next_brk, ext, next_ext;
   logic [KMS_NOTES-1:0] pressed, next_pressed;
   logic evt;
   logic [4:0] idx, key_low;
   kms_demo_t st, next_st;
   logic [KMS_TUNE_AW-1:0] addr, next_addr;
   logic [2:0] beats, next_beats;
   logic [31:0] cnt, next_cnt;
   logic [4:0] dnote, next_dnote;
   logic restart_q, restart_edge;
   logic [7:0] rom_data;
   logic [4:0] note, next_note;
   logic note_on;
   logic [31:0] phase, next_phase;
   logic [16:0] step;
   logic [9:0] tick, next_tick;
   logic tick_now;
   logic [14:0] tri_fold;
   logic [15:0] wave;
   logic [15:0] next_left, next_right;
   logic [KMS_NOTES-1:0] lit;
   logic [9:0] rel;
   logic [4:0] nat, sharp, key;
   logic in_piano, is_sharp, hit;
   logic [11:0] next_rgb;

   kms_ps2_if link ();

   kms_ps2_rx u_rx (
      .ps2_clk(PS2_CLK),
      .reset(RESET),
      .ps2_dat(PS2_DAT_I),
      .link(link.rx)
   );

   kms_tune_rom u_rom (
      .clk(MCLK),
      .reset(RESET),
      .addr(addr),
      .data(rom_data)
   );

   // The keyboard lines are only listened to; the host never inhibits.
   assign PS2_CLK_O = 1'b0;
   assign PS2_CLK_OE_N = 1'b1;
   assign PS2_DAT_O = 1'b0;
   assign PS2_DAT_OE_N = 1'b1;

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RESET);

   ////////////////////////////////////////////////////////////////////////
   // The button and switch pins and the link toggle cross through two flops before any use.
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin // [R6]
         sync1 <= 5'h10;
         sync2 <= 5'h10;
         tog1 <= 1'b0;
         tog2 <= 1'b0;
         tog3 <= 1'b0;
      end else begin
         sync1 <= {DEMO_RESTART_N, NOTE_SOURCE_SELECT, TIMBRE_SELECT,
                   CHANNEL_ONE_ENABLE, CHANNEL_TWO_ENABLE};
         sync2 <= sync1;
         tog1 <= link.toggle;
         tog2 <= tog1;
         tog3 <= tog2;
      end
   end
   assign {restart_n, src_sel, timbre, ch1_en, ch2_en} = sync2;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [4:0] key_index(input logic [7:0] c);
      case (c) // [R9]
         8'h15: key_index = 5'h00;
         8'h1C: key_index = 5'h01;
         8'h1D: key_index = 5'h02;
         8'h1B: key_index = 5'h03;
         8'h24: key_index = 5'h04;
         8'h23: key_index = 5'h05;
         8'h2B: key_index = 5'h06;
         8'h2C: key_index = 5'h07;
         8'h34: key_index = 5'h08;
         8'h35: key_index = 5'h09;
         8'h33: key_index = 5'h0A;
         8'h3B: key_index = 5'h0B;
         8'h43: key_index = 5'h0C;
         8'h42: key_index = 5'h0D;
         8'h44: key_index = 5'h0E;
         8'h4B: key_index = 5'h0F;
         8'h4D: key_index = 5'h10;
         8'h4C: key_index = 5'h11;
         8'h52: key_index = 5'h12;
         default: key_index = KMS_REST;
      endcase
   endfunction

   // The code word is stable for a whole frame after its toggle moves,
   // far longer than the crossing takes, so it is read directly here.
   assign evt = tog2 ^ tog3;
   assign idx = key_index(link.code);

   always_comb begin
      next_brk = brk;
      next_ext = ext;
      next_pressed = pressed;
      if (evt) begin
         if (link.code == KMS_CODE_BREAK) begin
            next_brk = 1'b1;
         end else if (link.code == KMS_CODE_EXT) begin
            next_ext = 1'b1;
         end else begin
            next_brk = 1'b0;
            next_ext = 1'b0;
            if (!ext && idx != KMS_REST) begin
               next_pressed[idx] = !brk; // [R8] [R10]
            end
         end
      end
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         brk <= 1'b0;
         ext <= 1'b0;
         pressed <= '0;
      end else begin
         brk <= next_brk;
         ext <= next_ext;
         pressed <= next_pressed;
      end
   end
   assign KEYS_HELD = pressed;

   property p_press;
      evt && !brk && !ext && link.code != KMS_CODE_BREAK &&
         link.code != KMS_CODE_EXT && idx != KMS_REST |=> pressed[$past(idx)];
   endproperty
   a_press: assert property (p_press) else $error("key press not held"); // [R8]

   property p_release;
      evt && brk && !ext && link.code != KMS_CODE_BREAK &&
         link.code != KMS_CODE_EXT && idx != KMS_REST
         |=> !pressed[$past(idx)];
   endproperty
   a_release: assert property (p_release) else $error("release kept key"); // [R10]

   property p_map;
      evt && !brk && !ext && link.code == 8'h1C |=> pressed[1];
   endproperty
   a_map: assert property (p_map) else $error("key A not note -5"); // [R9]

   ////////////////////////////////////////////////////////////////////////
   assign restart_edge = restart_q && !restart_n;

   always_comb begin
      next_st = st;
      next_addr = addr;
      next_beats = beats;
      next_cnt = cnt;
      next_dnote = dnote;
      case (st)
         KMS_IDLE: begin
            next_dnote = KMS_REST;
         end
         KMS_ADDR: begin
            next_st = KMS_LOAD;
         end
         KMS_LOAD: begin
            if (rom_data[7:5] == 3'h0) begin
               next_st = KMS_IDLE;
               next_dnote = KMS_REST;
            end else begin
               next_st = KMS_PLAY;
               next_beats = rom_data[7:5];
               next_cnt = 32'h0;
               next_dnote = rom_data[4:0];
            end
         end
         KMS_PLAY: begin
            if (cnt == 32'(BEAT_CYCLES - 1)) begin
               next_cnt = 32'h0;
               next_beats = beats - 3'h1;
               if (beats == 3'h1) begin
                  next_addr = addr + 1'b1;
                  next_st = KMS_ADDR;
               end
            end else begin
               next_cnt = cnt + 32'h1;
            end
         end
         default: begin
            next_st = KMS_IDLE;
         end
      endcase
      if (restart_edge) begin // [R3]
         next_st = KMS_ADDR;
         next_addr = '0;
      end
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         st <= KMS_IDLE;
         addr <= '0;
         beats <= 3'h0;
         cnt <= 32'h0;
         dnote <= KMS_REST;
         restart_q <= 1'b1;
      end else begin
         st <= next_st;
         addr <= next_addr;
         beats <= next_beats;
         cnt <= next_cnt;
         dnote <= next_dnote;
         restart_q <= restart_n;
      end
   end

   property p_restart;
      restart_edge |=> st == KMS_ADDR && addr == '0 ##2 st == KMS_PLAY;
   endproperty
   a_restart: assert property (p_restart) else $error("no tune restart"); // [R3]

   property p_store;
      st == KMS_LOAD && rom_data[7:5] != 3'h0 && !restart_edge
         |=> st == KMS_PLAY && dnote == $past(rom_data[4:0]);
   endproperty
   a_store: assert property (p_store) else $error("tune entry not used"); // [R1]

   ////////////////////////////////////////////////////////////////////////
   // The lowest held key sounds; the tone core is a single voice.
   always_comb begin
      key_low = KMS_REST;
      for (int i = KMS_NOTES - 1; i >= 0; i--) begin
         if (pressed[i]) begin
            key_low = 5'(i);
         end
      end
   end

   assign note_on = note != KMS_REST;
   assign step = (note < 5'(KMS_NOTES)) ? KMS_STEP[note] : 17'h00000;
   assign tick_now = tick == 10'(KMS_SAMPLE_CYC - 1);
   assign tri_fold = phase[31] ? ~phase[30:16] : phase[30:16];
   assign wave = timbre ? ({tri_fold, 1'b0} ^ 16'h8000) // [R4]
                        : {~phase[31], phase[30:16]};

   always_comb begin
      next_note = src_sel ? key_low : dnote; // [R2] [R10]
      next_phase = note_on ? phase + {15'h0000, step} : 32'h0;
      next_tick = tick_now ? 10'h000 : tick + 10'h001;
      next_left = AUDIO_LEFT;
      next_right = AUDIO_RIGHT;
      if (tick_now) begin
         next_left = (ch1_en && note_on) ? wave : 16'h0000; // [R5]
         next_right = (ch2_en && note_on) ? wave : 16'h0000; // [R5]
      end
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         note <= KMS_REST;
         phase <= 32'h0;
         tick <= 10'h000;
         AUDIO_LEFT <= 16'h0000;
         AUDIO_RIGHT <= 16'h0000;
         AUDIO_VALID <= 1'b0;
      end else begin
         note <= next_note;
         phase <= next_phase;
         tick <= next_tick;
         AUDIO_LEFT <= next_left;
         AUDIO_RIGHT <= next_right;
         AUDIO_VALID <= tick_now;
      end
   end

   property p_source;
      !src_sel && st == KMS_PLAY |=> note == $past(dnote);
   endproperty
   a_source: assert property (p_source) else $error("tune not source"); // [R2]

   property p_timbre;
      tick_now && ch1_en && note_on |=> AUDIO_VALID && ($past(timbre)
         ? AUDIO_LEFT == ({$past(tri_fold), 1'b0} ^ 16'h8000)
         : AUDIO_LEFT == {~$past(phase[31]), $past(phase[30:16])});
   endproperty
   a_timbre: assert property (p_timbre) else $error("wrong timbre"); // [R4]

   property p_mute;
      tick_now && !ch2_en |=> AUDIO_RIGHT == 16'h0000 && AUDIO_VALID;
   endproperty
   a_mute: assert property (p_mute) else $error("channel two not muted"); // [R5]

   property p_silent;
      tick_now && !note_on |=> AUDIO_LEFT == 16'h0000 &&
         AUDIO_RIGHT == 16'h0000;
   endproperty
   a_silent: assert property (p_silent) else $error("sound with no note"); // [R10]

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      lit = '0;
      for (int i = 0; i < KMS_NOTES; i++) begin
         lit[i] = src_sel ? pressed[i] : (dnote == 5'(i)); // [R7]
      end
   end

   assign in_piano = VGA_X >= KMS_PIANO_X0 && VGA_X < KMS_PIANO_X1 &&
                     VGA_Y >= KMS_PIANO_Y0 && VGA_Y < KMS_PIANO_Y1;
   assign rel = VGA_X - KMS_PIANO_X0;
   assign nat = (rel[8:5] < 4'(KMS_NATS)) ? KMS_NAT[rel[8:5]] : 5'h00;

   // Black keys sit across the seam between two white keys, upper half.
   always_comb begin
      sharp = KMS_REST;
      if (VGA_Y < KMS_SHARP_Y && rel[4:0] >= KMS_SHARP_HI) begin
         sharp = nat + 5'h01;
      end else if (VGA_Y < KMS_SHARP_Y && rel[4:0] < KMS_SHARP_LO) begin
         sharp = nat - 5'h01;
      end
      is_sharp = sharp < 5'(KMS_NOTES) && KMS_SHARP[sharp];
      key = is_sharp ? sharp : nat;
      hit = in_piano && lit[key];
      if (!in_piano) begin
         next_rgb = KMS_RGB_BACK;
      end else if (hit) begin
         next_rgb = KMS_RGB_LIT;
      end else if (is_sharp || rel[4:0] == 5'h00) begin
         next_rgb = KMS_RGB_BLACK;
      end else begin
         next_rgb = KMS_RGB_WHITE;
      end
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         {VGA_R, VGA_G, VGA_B} <= 12'h000;
      end else begin
         {VGA_R, VGA_G, VGA_B} <= next_rgb; // [R7]
      end
   end

   property p_draw;
      hit |=> VGA_R == 4'hF && VGA_G == 4'h0 && VGA_B == 4'h0;
   endproperty
   a_draw: assert property (p_draw) else $error("held key not lit"); // [R7]
endmodule
`default_nettype wire

/* File: testbench/kms_kbd_model.sv */
`timescale 1ns/10ps
`default_nettype none
module kms_kbd_model (
   output logic kbd_clk,
   output logic kbd_dat
);
   // The keyboard owns both lines. Between frames the clock stands high
   // and the data line floats to its pull-up.
   initial begin
      kbd_clk = 1'b1;
      kbd_dat = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // One frame at a 32 ns bit time. Data changes while the clock is high,
   // so it is stable at every falling edge where the receiver samples it.
   task automatic send(input logic [7:0] code, input logic bad_parity);
      logic [10:0] frame;
      frame = {1'b1, (~^code) ^ bad_parity, code, 1'b0};
      #5;
      for (int i = 0; i < 11; i++) begin
         kbd_dat = frame[i];
         #8 kbd_clk = 1'b0;
         #16 kbd_clk = 1'b1;
         #8;
      end
      kbd_dat = 1'b1;
   endtask
endmodule
`default_nettype wire

/* File: testbench/kms_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define KMS_CHK(got, exp) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) begin \
         mismatches++; \
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, \
            (got), (exp)); \
      end \
   end
module kms_top_tb_top;
   import kms_pkg::*;
   logic mclk, reset, restart_n, src, timbre, ch1, ch2;
   logic kbd_clk, kbd_dat, ps2_clk, ps2_dat;
   logic ps2_clk_o, ps2_clk_oe_n, ps2_dat_o, ps2_dat_oe_n;
   logic [9:0] vga_x, vga_y;
   logic [3:0] vga_r, vga_g, vga_b;
   logic [15:0] aud_l, aud_r;
   logic aud_v;
   logic [KMS_NOTES-1:0] keys, one;
   logic [63:0] brass_s, strg_s;
   int mismatches, checks_done;
   localparam logic [7:0] CODES [KMS_NOTES] = '{8'h15, 8'h1C, 8'h1D, 8'h1B,
      8'h24, 8'h23, 8'h2B, 8'h2C, 8'h34, 8'h35, 8'h33, 8'h3B, 8'h43, 8'h42,
      8'h44, 8'h4B, 8'h4D, 8'h4C, 8'h52};

   // Open-drain wires: low wins, otherwise the pull-up holds them high.
   assign ps2_clk = kbd_clk & (ps2_clk_oe_n | ps2_clk_o);
   assign ps2_dat = kbd_dat & (ps2_dat_oe_n | ps2_dat_o);

   kms_kbd_model kbd (.kbd_clk(kbd_clk), .kbd_dat(kbd_dat));

   // The tune must span several audio samples yet end within six of them.
   kms_top #(.BEAT_CYCLES(150)) dut (
      .MCLK(mclk), .RESET(reset), .DEMO_RESTART_N(restart_n),
      .NOTE_SOURCE_SELECT(src), .TIMBRE_SELECT(timbre),
      .CHANNEL_ONE_ENABLE(ch1), .CHANNEL_TWO_ENABLE(ch2),
      .PS2_CLK(ps2_clk), .PS2_DAT_I(ps2_dat),
      .PS2_CLK_O(ps2_clk_o), .PS2_CLK_OE_N(ps2_clk_oe_n),
      .PS2_DAT_O(ps2_dat_o), .PS2_DAT_OE_N(ps2_dat_oe_n),
      .VGA_X(vga_x), .VGA_Y(vga_y), .VGA_R(vga_r), .VGA_G(vga_g),
      .VGA_B(vga_b), .AUDIO_LEFT(aud_l), .AUDIO_RIGHT(aud_r),
      .AUDIO_VALID(aud_v), .KEYS_HELD(keys));

   always #20 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic do_reset();
      @(posedge mclk);
      reset <= 1'b1;
      @(posedge mclk);
      #1;
      `KMS_CHK({aud_l, aud_r, aud_v, keys, vga_r, vga_g, vga_b}, '0)
      `KMS_CHK({ps2_clk_oe_n, ps2_dat_oe_n, ps2_clk_o, ps2_dat_o}, 4'hC)
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask

   task automatic key(input logic [7:0] code, input logic up);
      if (up) kbd.send(KMS_CODE_BREAK, 1'b0);
      kbd.send(code, 1'b0);
      repeat (8) @(posedge mclk);
      #1;
   endtask

   task automatic next_sample(output logic [15:0] l, output logic [15:0] r);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (aud_v !== 1'b1 && n < 600);
      if (n >= 600) begin
         mismatches++;
         $display("CHECK FAILED at %0t: no audio sample", $time);
      end
      l = aud_l;
      r = aud_r;
   endtask

   // The first sample after a switch change may predate the synchroniser.
   task automatic chan_check(input logic exp_l, input logic exp_r);
      logic [15:0] l, r;
      logic nl, nr;
      nl = 1'b0;
      nr = 1'b0;
      next_sample(l, r);
      repeat (4) begin
         next_sample(l, r);
         nl |= (l != 16'h0000);
         nr |= (r != 16'h0000);
      end
      `KMS_CHK({nl, nr}, {exp_l, exp_r})
   endtask

   task automatic grab(output logic [63:0] w);
      logic [15:0] l, r;
      w = '0;
      repeat (4) begin
         next_sample(l, r);
         w = {w[47:0], l};
      end
   endtask

   task automatic vga(input logic [9:0] x, input logic [9:0] y,
                      input logic [11:0] exp);
      @(posedge mclk);
      vga_x <= x;
      vga_y <= y;
      @(posedge mclk);
      #1;
      `KMS_CHK({vga_r, vga_g, vga_b}, exp)
   endtask

   task automatic restart();
      @(posedge mclk);
      restart_n <= 1'b0;
      repeat (4) @(posedge mclk);
      restart_n <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #2000000;
      mismatches++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      mclk = 1'b0;
      reset = 1'b1;
      restart_n = 1'b1;
      src = 1'b0;
      timbre = 1'b0;
      ch1 = 1'b1;
      ch2 = 1'b1;
      vga_x = 10'h000;
      vga_y = 10'h000;
      mismatches = 0;
      checks_done = 0;
      do_reset();
      src <= 1'b1;
      repeat (3) @(posedge mclk);
      for (int i = 0; i < KMS_NOTES; i++) begin
         one = {{(KMS_NOTES-1){1'b0}}, 1'b1} << i;
         key(CODES[i], 1'b0);
         `KMS_CHK(keys, one)
         key(CODES[i], 1'b1);
         `KMS_CHK(keys, '0)
      end
      kbd.send(8'h2B, 1'b1);
      repeat (8) @(posedge mclk);
      #1;
      `KMS_CHK(keys, '0)
      kbd.send(KMS_CODE_EXT, 1'b0);
      key(8'h2B, 1'b0);
      `KMS_CHK(keys, '0)
      key(8'h2B, 1'b0);
      `KMS_CHK(keys[6], 1'b1)
      vga(10'h000, 10'h000, KMS_RGB_BACK);
      vga(10'h0F0, 10'h12C, KMS_RGB_LIT);
      vga(10'h100, 10'h0C8, KMS_RGB_BLACK);
      vga(10'h110, 10'h12C, KMS_RGB_WHITE);
      @(posedge mclk);
      ch2 <= 1'b0;
      chan_check(1'b1, 1'b0);
      @(posedge mclk);
      ch1 <= 1'b0;
      ch2 <= 1'b1;
      chan_check(1'b0, 1'b1);
      key(8'h2B, 1'b1);
      chan_check(1'b0, 1'b0);
      @(posedge mclk);
      ch1 <= 1'b1;
      restart();
      chan_check(1'b0, 1'b0);
      @(posedge mclk);
      src <= 1'b0;
      repeat (3) @(posedge mclk);
      restart();
      chan_check(1'b1, 1'b1);
      chan_check(1'b0, 1'b0);
      restart();
      chan_check(1'b1, 1'b1);
      do_reset();
      src <= 1'b1;
      key(8'h2B, 1'b0);
      grab(brass_s);
      do_reset();
      src <= 1'b1;
      timbre <= 1'b1;
      key(8'h2B, 1'b0);
      grab(strg_s);
      `KMS_CHK(brass_s !== strg_s, 1'b1)
      report_and_stop();
   end
endmodule
`default_nettype wire
